/* hw/phys_filter_pkg.sv */
// Package with the register map, field positions and carrier types of the physical request filter
package phys_filter_pkg;

  // Bus geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_UPPER_SET   = 9'h110;
  localparam logic [ADDR_W-1:0] OFS_UPPER_CLEAR = 9'h114;
  localparam logic [ADDR_W-1:0] OFS_LOWER_SET   = 9'h118;
  localparam logic [ADDR_W-1:0] OFS_LOWER_CLEAR = 9'h11C;
  localparam logic [ADDR_W-1:0] OFS_UPPER_BOUND = 9'h120;

  // Reset and fixed values
  localparam logic [DATA_W-1:0] BANK_RESET      = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UPPER_BOUND_VAL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL    = 32'h0000_0000;

  // Node numbering
  localparam int NODE_W          = 6;
  localparam int LOWER_NODES     = 32;
  localparam int UPPER_NODE_BASE = 32;
  localparam int UPPER_NODE_LAST = 62;
  localparam int ALL_BUS_BIT     = 31;

  // Incoming request to classify
  typedef struct packed {
    logic              valid;
    logic [NODE_W-1:0] src_node;
    logic              local_bus;
    logic              async_ok;
  } filt_req_t;

  // Routing verdict
  typedef struct packed {
    logic valid;
    logic to_phys;
    logic to_async;
    logic rejected;
  } route_t;

  // Bus handshake states
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage : phys_filter_pkg

/* hw/phys_filter_bank.sv */
// Set/clear filter bank register with byte enables
`timescale 1ns/1ps
module phys_filter_bank #(
  parameter int WIDTH = 32
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               set_en,
  input  wire logic               clr_en,
  input  wire logic [WIDTH-1:0]   wr_data,
  input  wire logic [WIDTH/8-1:0] byte_en,
  output logic      [WIDTH-1:0]   bits
);

  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } bank_state_t;

  bank_state_t      state;
  bank_state_t      next_state;
  logic [WIDTH-1:0] lane_mask;

  // Width must be whole bytes
  if (WIDTH % 8 != 0 || WIDTH == 0) begin : g_bad_width
    $error("phys_filter_bank: WIDTH must be a nonzero multiple of 8");
  end

  // Byte enables widened to a bit mask
  for (genvar i = 0; i < WIDTH; i++) begin : g_mask
    assign lane_mask[i] = byte_en[i/8];
  end

  // Ones written to set address set bits, ones to clear address clear them
  always_comb begin
    next_state = state;
    if (set_en) begin
      next_state.bits = state.bits | (wr_data & lane_mask);
    end else if (clr_en) begin
      next_state.bits = state.bits & ~(wr_data & lane_mask);
    end
  end

  // State register, cleared on reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state.bits <= phys_filter_pkg::BANK_RESET[WIDTH-1:0];
    end else begin
      state <= next_state;
    end
  end

  assign bits = state.bits;

endmodule : phys_filter_bank

/* hw/physical_request_filter.sv */
// Physical request filter: two set/clear banks on Avalon-MM and the per-node routing decision
`timescale 1ns/1ps
module physical_request_filter #(
  parameter int NODE_W = phys_filter_pkg::NODE_W
) (
  input  wire logic                               sys_clk,
  input  wire logic                               rst_n,
  input  wire logic [phys_filter_pkg::ADDR_W-1:0] address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire logic [phys_filter_pkg::DATA_W-1:0] writedata,
  input  wire logic [phys_filter_pkg::BE_W-1:0]   byteenable,
  output logic      [phys_filter_pkg::DATA_W-1:0] readdata,
  output logic                                    waitrequest,
  input  wire phys_filter_pkg::filt_req_t         filt_req,
  output phys_filter_pkg::route_t                 route,
  output logic      [phys_filter_pkg::DATA_W-1:0] lower_enables,
  output logic      [phys_filter_pkg::DATA_W-1:0] upper_enables
);

  localparam int DW = phys_filter_pkg::DATA_W;

  // Node numbering must fit the two banks
  if (NODE_W != phys_filter_pkg::NODE_W) begin : g_bad_node_w
    $error("physical_request_filter: NODE_W must match the bank layout");
  end

  typedef struct packed {
    phys_filter_pkg::bus_state_t bus_state;
    logic                        waitrequest;
    logic [DW-1:0]               readdata;
    phys_filter_pkg::route_t     route;
    logic [DW-1:0]               lower_copy;
    logic [DW-1:0]               upper_copy;
  } top_state_t;

  top_state_t    state;
  top_state_t    next_state;
  logic [DW-1:0] lower_bits;
  logic [DW-1:0] upper_bits;
  logic          take;
  logic          upper_set_en;
  logic          upper_clr_en;
  logic          lower_set_en;
  logic          lower_clr_en;

  // True when the address equals the given offset; read, write and bus state are not checked here
  function automatic logic addr_hit(input logic [phys_filter_pkg::ADDR_W-1:0] a,
                                    input logic [phys_filter_pkg::ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : addr_hit

  // Enable bit of one node on the local bus; node 63 has no bit
  function automatic logic node_enabled(input logic [NODE_W-1:0] node,
                                        input logic [DW-1:0]     lower,
                                        input logic [DW-1:0]     upper);
    logic [NODE_W-1:0] idx;
    idx = '0;
    if (node < NODE_W'(phys_filter_pkg::LOWER_NODES)) begin
      return lower[node[4:0]];
    end else if (node <= NODE_W'(phys_filter_pkg::UPPER_NODE_LAST)) begin
      idx = node - NODE_W'(phys_filter_pkg::UPPER_NODE_BASE);
      return upper[idx[4:0]];
    end
    return 1'b0;
  endfunction : node_enabled

  // Request is taken in the cycle it appears while idle
  assign take = (read || write) && state.bus_state == phys_filter_pkg::BUS_IDLE;

  // Write strobes; upper bound and unmapped addresses produce none
  assign upper_set_en = take && write && addr_hit(address, phys_filter_pkg::OFS_UPPER_SET);
  assign upper_clr_en = take && write && addr_hit(address, phys_filter_pkg::OFS_UPPER_CLEAR);
  assign lower_set_en = take && write && addr_hit(address, phys_filter_pkg::OFS_LOWER_SET);
  assign lower_clr_en = take && write && addr_hit(address, phys_filter_pkg::OFS_LOWER_CLEAR);

  // Upper bank: nodes 32..62 plus remote-bus accept
  phys_filter_bank #(
    .WIDTH(DW)
  ) u_upper_bank (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_en  (upper_set_en),
    .clr_en  (upper_clr_en),
    .wr_data (writedata),
    .byte_en (byteenable),
    .bits    (upper_bits)
  );

  // Lower bank: nodes 0..31
  phys_filter_bank #(
    .WIDTH(DW)
  ) u_lower_bank (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_en  (lower_set_en),
    .clr_en  (lower_clr_en),
    .wr_data (writedata),
    .byte_en (byteenable),
    .bits    (lower_bits)
  );

  // Bus handshake, read mux and routing decision
  always_comb begin
    next_state            = state;
    next_state.lower_copy = lower_bits;
    next_state.upper_copy = upper_bits;
    case (state.bus_state)
      phys_filter_pkg::BUS_IDLE: begin
        if (take) begin
          next_state.bus_state   = phys_filter_pkg::BUS_ACK;
          next_state.waitrequest = 1'b0;
          next_state.readdata    = phys_filter_pkg::UNMAPPED_VAL;
          if (read) begin
            if (addr_hit(address, phys_filter_pkg::OFS_UPPER_SET) ||
                addr_hit(address, phys_filter_pkg::OFS_UPPER_CLEAR)) begin
              next_state.readdata = upper_bits;
            end else if (addr_hit(address, phys_filter_pkg::OFS_LOWER_SET) ||
                         addr_hit(address, phys_filter_pkg::OFS_LOWER_CLEAR)) begin
              next_state.readdata = lower_bits;
            end else if (addr_hit(address, phys_filter_pkg::OFS_UPPER_BOUND)) begin
              next_state.readdata = phys_filter_pkg::UPPER_BOUND_VAL;
            end
          end
        end
      end
      phys_filter_pkg::BUS_ACK: begin
        next_state.bus_state   = phys_filter_pkg::BUS_IDLE;
        next_state.waitrequest = 1'b1;
      end
      default: begin
        next_state.bus_state   = phys_filter_pkg::BUS_IDLE;
        next_state.waitrequest = 1'b1;
      end
    endcase

    // Async filter verdict gates first, physical bits decide second
    next_state.route = '0;
    if (filt_req.valid) begin
      next_state.route.valid = 1'b1;
      if (!filt_req.async_ok) begin
        next_state.route.rejected = 1'b1;
      end else if (filt_req.local_bus ? node_enabled(filt_req.src_node, lower_bits, upper_bits)
                                      : upper_bits[phys_filter_pkg::ALL_BUS_BIT]) begin
        next_state.route.to_phys = 1'b1;
      end else begin
        next_state.route.to_async = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state.bus_state   <= phys_filter_pkg::BUS_IDLE;
      state.waitrequest <= 1'b1;
      state.readdata    <= phys_filter_pkg::UNMAPPED_VAL;
      state.route       <= '0;
      state.lower_copy  <= phys_filter_pkg::BANK_RESET;
      state.upper_copy  <= phys_filter_pkg::BANK_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign readdata      = state.readdata;
  assign waitrequest   = state.waitrequest;
  assign route         = state.route;
  assign lower_enables = state.lower_copy;
  assign upper_enables = state.upper_copy;

endmodule : physical_request_filter

/* dv/phys_filter_props.sv */
// Checker for bus handshake, bank updates and routing verdicts
`timescale 1ns/1ps
module phys_filter_props #(
  parameter int NODE_W = 6
) (
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  input wire logic [8:0]                 address,
  input wire logic                       read,
  input wire logic                       write,
  input wire logic [31:0]                writedata,
  input wire logic [3:0]                 byteenable,
  input wire logic [31:0]                readdata,
  input wire logic                       waitrequest,
  input wire phys_filter_pkg::filt_req_t filt_req,
  input wire phys_filter_pkg::route_t    route,
  input wire logic [31:0]                lower_enables,
  input wire logic [31:0]                upper_enables
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic lreq;
  logic ack;
  // Accepted local request and completed access with all four byte enables set
  assign lreq = filt_req.valid && filt_req.async_ok && filt_req.local_bus;
  assign ack  = !waitrequest && byteenable == 4'hF;
  a_route_next: assert property (filt_req.valid |=> route.valid) else $error("no verdict after request");
  a_route_quiet: assert property (!filt_req.valid |=> !route.valid) else $error("verdict without request");
  a_one_verdict: assert property (route.valid |-> $onehot({route.to_phys, route.to_async, route.rejected}))
    else $error("verdict not one-hot");
  a_reject_async: assert property (filt_req.valid && !filt_req.async_ok |=> route.rejected)
    else $error("async-refused request not rejected");
  a_lower_gate: assert property (lreq && filt_req.src_node < 6'h20 |=>
    route.to_phys == lower_enables[$past(filt_req.src_node)]) else $error("lower node misrouted");
  a_upper_gate: assert property (lreq && filt_req.src_node inside {[6'h20:6'h3E]} |=>
    route.to_phys == upper_enables[$past(filt_req.src_node) - 6'h20]) else $error("upper node misrouted");
  a_remote_bus: assert property (filt_req.valid && filt_req.async_ok && !filt_req.local_bus |=>
    route.to_phys == upper_enables[31]) else $error("remote bus misrouted");
  a_wait_single: assert property (!waitrequest |=> waitrequest) else $error("ack longer than one cycle");
  a_ack_bound: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("access not acknowledged");
  a_bound_zero: assert property (read && !waitrequest && address == phys_filter_pkg::OFS_UPPER_BOUND |->
    readdata == 32'h0000_0000) else $error("upper bound not zero");
  a_set_lower: assert property (write && ack && address == phys_filter_pkg::OFS_LOWER_SET |=>
    (lower_enables & $past(writedata)) == $past(writedata)) else $error("lower set lost");
  a_clr_upper: assert property (write && ack && address == phys_filter_pkg::OFS_UPPER_CLEAR |=>
    (upper_enables & $past(writedata)) == 32'h0000_0000) else $error("upper clear lost");
  // Main scenarios reached
  c_remote: cover property (filt_req.valid && filt_req.async_ok && !filt_req.local_bus);
  c_reject: cover property (route.rejected);
  c_phys: cover property (route.to_phys);
endmodule : phys_filter_props
bind physical_request_filter phys_filter_props #(.NODE_W(NODE_W)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .filt_req(filt_req), .route(route),
  .lower_enables(lower_enables), .upper_enables(upper_enables));

/* dv/remote_node_model.sv */
// Remote node model issuing one-cycle requests
`timescale 1ns/1ps
module remote_node_model (
  input  wire logic                  sys_clk,
  input  wire logic                  fire,
  input  wire logic [5:0]            node,
  input  wire logic                  loc,
  input  wire logic                  aok,
  output phys_filter_pkg::filt_req_t filt_req
);
  initial filt_req = '0;
  // Pulse per request; idle fields scrambled so stale values are never trusted
  always @(posedge sys_clk) begin
    filt_req <= fire ? {1'h1, node, loc, aok} : {1'h0, ~filt_req.src_node, ~filt_req.local_bus, ~filt_req.async_ok};
  end
endmodule : remote_node_model

/* dv/tb_physical_request_filter.sv */
// Testbench for the physical request filter
`timescale 1ns/1ps
module tb_physical_request_filter;
  logic                       sys_clk, rst_n, read, write, fire, loc, aok, waitrequest;
  logic [8:0]                 address;
  logic [31:0]                writedata, readdata, lower_enables, upper_enables, exp_lo, exp_hi, q, d, m;
  logic [3:0]                 byteenable, be;
  logic [5:0]                 node;
  phys_filter_pkg::filt_req_t filt_req;
  phys_filter_pkg::route_t    route;
  int                         n_fail = 0, n_compared = 0, cyc = 0, k;
  logic [8:0]                 ofs [6] = '{9'h110, 9'h114, 9'h118, 9'h11C, 9'h120, 9'h100};
  logic [5:0]                 corner [7] = '{6'h00, 6'h1F, 6'h20, 6'h31, 6'h32, 6'h3E, 6'h3F};
  physical_request_filter uut (.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .filt_req(filt_req), .route(route), .lower_enables(lower_enables), .upper_enables(upper_enables));
  remote_node_model peer (.sys_clk(sys_clk), .fire(fire), .node(node), .loc(loc), .aok(aok), .filt_req(filt_req));
  // Clock and hang guard
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] lanes(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction : lanes
  // Expected verdict {phys, async, rejected}
  function automatic logic [2:0] verdict(input logic [5:0] n, input logic l, input logic a);
    logic en;
    en = !l ? exp_hi[31] : n < 6'h20 ? exp_lo[n[4:0]] : n < 6'h3F ? exp_hi[n - 6'h20] : 1'h0;
    return !a ? 3'h1 : en ? 3'h4 : 3'h2;
  endfunction : verdict
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] wd, input logic [3:0] b);
    int n;
    n = 0;
    read <= !wr; write <= wr; address <= a; writedata <= wd; byteenable <= b;
    @(posedge sys_clk);
    while (waitrequest !== 1'h0 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    q = readdata;
    check("ack", n < 20, 1'h1);
    read <= 1'h0; write <= 1'h0;
    @(posedge sys_clk);
  endtask : bus
  task automatic req(input logic [5:0] n, input logic l, input logic a);
    fire <= 1'h1; node <= n; loc <= l; aok <= a;
    @(posedge sys_clk);
    fire <= 1'h0;
    repeat (2) @(posedge sys_clk);
    check("route", {28'h0, route}, {28'h0, 1'h1, verdict(n, l, a)});
  endtask : req
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    rst_n = 1'h0; read = 1'h0; write = 1'h0; address = '0; writedata = '0; byteenable = '0;
    fire = 1'h0; node = '0; loc = 1'h0; aok = 1'h0; exp_lo = '0; exp_hi = '0;
    void'($urandom(67));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    foreach (ofs[i]) begin
      bus(1'h0, ofs[i], '0, 4'hF);
      check("reset read", q, 32'h0000_0000);
    end
    $display("reset test done");
    bus(1'h1, phys_filter_pkg::OFS_LOWER_SET, 32'h8000_0001, 4'hF);
    exp_lo = 32'h8000_0001;
    bus(1'h1, phys_filter_pkg::OFS_UPPER_CLEAR, 32'hFFFF_FFFF, 4'hF);
    repeat (40) begin
      k = $urandom_range(3); d = $urandom; be = $urandom_range(15);
      bus(1'h1, ofs[k], d, be);
      m = d & lanes(be);
      case (k)
        0: exp_hi |= m;
        1: exp_hi &= ~m;
        2: exp_lo |= m;
        default: exp_lo &= ~m;
      endcase
      bus(1'h0, phys_filter_pkg::OFS_UPPER_SET, '0, 4'hF);
      check("upper bank", q, exp_hi);
      bus(1'h0, phys_filter_pkg::OFS_LOWER_CLEAR, '0, 4'hF);
      check("lower bank", q, exp_lo);
      check("lower copy", lower_enables, exp_lo);
      check("upper copy", upper_enables, exp_hi);
      repeat (3) req($urandom_range(1) ? corner[$urandom_range(6)] : 6'($urandom), $urandom_range(7) != 0,
        $urandom_range(7) != 0);
    end
    $display("bank and routing test done");
    bus(1'h1, phys_filter_pkg::OFS_UPPER_BOUND, 32'hFFFF_FFFF, 4'hF);
    bus(1'h1, 9'h100, 32'hFFFF_FFFF, 4'hF);
    bus(1'h0, phys_filter_pkg::OFS_UPPER_BOUND, '0, 4'hF);
    check("upper bound", q, 32'h0000_0000);
    bus(1'h0, phys_filter_pkg::OFS_LOWER_SET, '0, 4'hF);
    check("lower kept", q, exp_lo);
    bus(1'h0, phys_filter_pkg::OFS_UPPER_CLEAR, '0, 4'hF);
    check("upper kept", q, exp_hi);
    $display("read-only test done");
    results();
  end
endmodule : tb_physical_request_filter
